//--- common/itc_params.svh
// Constants of the interval and event count timer
`ifndef ITC_PARAMS_SVH
`define ITC_PARAMS_SVH
// ----------------------------------------------------------------------
// Counter geometry
// ----------------------------------------------------------------------
`define ITC_CNT_W 16
`define ITC_CNT_ZERO 16'h0000
`define ITC_CNT_ONE 16'h0001
`define ITC_CNT_MAX 16'hFFFF
`define ITC_NUM_CH 3
`define ITC_CH_MSB 47
// ----------------------------------------------------------------------
// Timer mode field codes
// ----------------------------------------------------------------------
`define ITC_MODE_INTERVAL 3'h0
`define ITC_MODE_EVENT 3'h1
// ----------------------------------------------------------------------
// Event edge select codes
// ----------------------------------------------------------------------
`define ITC_EDGE_NONE 2'h0
`define ITC_EDGE_RISE 2'h1
`define ITC_EDGE_FALL 2'h2
`define ITC_EDGE_BOTH 2'h3
`endif

//--- common/itc_pkg.sv
// Types shared by the interval and event count timer
package itc_pkg;
    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef logic [15:0] itc_count_t;
    typedef enum logic [1:0] {ITC_IDLE, ITC_ARMED, ITC_RUN} itc_state_e;
endpackage

//--- rtl/itc_timer.sv
// Interval and event count timer unit with three channel compares
`include "itc_params.svh"
module itc_timer
(
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic CE_I,
    input wire logic COUNT_ENABLE_I,
    input wire logic [2:0] TIMER_MODE_I,
    input wire logic EVENT_SOURCE_SELECT_I,
    input wire logic [1:0] EVENT_EDGE_SEL_I,
    input wire logic COUNT_TICK_I,
    input wire logic EVENT_COUNT_I,
    input wire logic [15:0] PERIOD_COMPARE_I,
    input wire logic PERIOD_WR_I,
    input wire logic [`ITC_CH_MSB:0] CHANNEL_COMPARE_I,
    input wire logic [`ITC_NUM_CH-1:0] CHANNEL_WR_I,
    output logic [15:0] COUNTER_O,
    output logic PERIOD_MATCH_IRQ_O,
    output logic [`ITC_NUM_CH-1:0] CHANNEL_MATCH_IRQ_O,
    output logic PERIOD_TOGGLE_OUT_O,
    output logic [`ITC_NUM_CH-1:0] CHANNEL_TOGGLE_OUT_O,
    output logic [`ITC_NUM_CH:0] TOGGLE_OE_O
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    itc_pkg::itc_state_e state;
    itc_pkg::itc_state_e next_state;
    itc_pkg::itc_count_t count;
    itc_pkg::itc_count_t next_count;
    itc_pkg::itc_count_t period_compare_buffer;
    itc_pkg::itc_count_t channel_compare_buffers [`ITC_NUM_CH];
    logic ev_s1;
    logic ev_s2;
    logic ev_s3;
    logic ev_lvl;
    logic next_ev_lvl;
    logic ev_rise;
    logic ev_fall;
    logic ev_edge;
    logic enable_q;
    logic enable_rise;
    logic mode_interval;
    logic mode_event;
    logic mode_ok;
    logic use_events;
    logic tick;
    logic run_tick;
    logic start_tick;
    logic period_hit;
    logic period_toggle;
    logic [`ITC_NUM_CH-1:0] channel_hit;

    // ------------------------------------------------------------------
    // Event input synchroniser
    // ------------------------------------------------------------------
    // Three stages; the first feeds only the second
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ev_s1 <= 1'b0;
            ev_s2 <= 1'b0;
            ev_s3 <= 1'b0;
            ev_lvl <= 1'b0;
        end
        else if (CE_I)
        begin
            ev_s1 <= EVENT_COUNT_I;
            ev_s2 <= ev_s1;
            ev_s3 <= ev_s2;
            ev_lvl <= next_ev_lvl;
        end
    end

    // A level change counts only once two stages agree, rejecting glitches
    assign next_ev_lvl = (ev_s2 == ev_s3) ? ev_s3 : ev_lvl;
    assign ev_rise = next_ev_lvl & ~ev_lvl;
    assign ev_fall = ~next_ev_lvl & ev_lvl;
    assign ev_edge = ((EVENT_EDGE_SEL_I == `ITC_EDGE_RISE) & ev_rise)
        | ((EVENT_EDGE_SEL_I == `ITC_EDGE_FALL) & ev_fall)
        | ((EVENT_EDGE_SEL_I == `ITC_EDGE_BOTH) & (ev_rise | ev_fall));

    // ------------------------------------------------------------------
    // Mode and count source decode
    // ------------------------------------------------------------------
    // Unsupported mode codes simply keep the counter parked
    assign mode_interval = (TIMER_MODE_I == `ITC_MODE_INTERVAL);
    assign mode_event = (TIMER_MODE_I == `ITC_MODE_EVENT);
    assign mode_ok = mode_interval | mode_event;
    assign use_events = mode_event | EVENT_SOURCE_SELECT_I;
    assign tick = use_events ? ev_edge : COUNT_TICK_I;
    assign enable_rise = COUNT_ENABLE_I & ~enable_q;
    // Event count mode clears at once, so its first match takes D0 edges
    assign start_tick = (state == itc_pkg::ITC_ARMED)
        & (tick | mode_event);
    assign run_tick = (state == itc_pkg::ITC_RUN) & tick;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // In interval mode ARMED waits for a first count that clears
    // FFFFH to 0000H and toggles the period output; event count mode leaves ARMED on the next clock, without waiting for an edge
    always_comb
    begin
        next_state = state;
        unique case (state)
            itc_pkg::ITC_IDLE:
            begin
                if (enable_rise && mode_ok)
                    next_state = itc_pkg::ITC_ARMED;
            end
            itc_pkg::ITC_ARMED:
            begin
                if (!COUNT_ENABLE_I || !mode_ok)
                    next_state = itc_pkg::ITC_IDLE;
                else if (start_tick)
                    next_state = itc_pkg::ITC_RUN;
            end
            itc_pkg::ITC_RUN:
            begin
                if (!COUNT_ENABLE_I || !mode_ok)
                    next_state = itc_pkg::ITC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Counter next value and compare hits
    // ------------------------------------------------------------------
    // Match is seen as the counter lands on a value; the clear follows
    // on the next count, so a period spans D0+1 counts
    assign next_count = start_tick ? `ITC_CNT_ZERO
        : (count == period_compare_buffer) ? `ITC_CNT_ZERO
        : count + `ITC_CNT_ONE;
    assign period_hit = run_tick
        & (next_count == period_compare_buffer);
    assign period_toggle = mode_interval
        & (period_hit | start_tick);

    // Channel compares never feed the clear path
    genvar gi;
    generate
        for (gi = 0; gi < `ITC_NUM_CH; gi++)
        begin : g_ch
            assign channel_hit[gi] = run_tick
                & (next_count == channel_compare_buffers[gi]);

            // Buffer follows any rewrite at once and reloads on start
            always_ff @(posedge REF_CLK_I or posedge RST_I)
            begin
                if (RST_I)
                    channel_compare_buffers[gi] <= `ITC_CNT_MAX;
                else if (CE_I && (CHANNEL_WR_I[gi] || enable_rise))
                    channel_compare_buffers[gi] <=
                        CHANNEL_COMPARE_I[gi*`ITC_CNT_W +: `ITC_CNT_W];
            end

            // Channel output toggles only in interval mode
            always_ff @(posedge REF_CLK_I or posedge RST_I)
            begin
                if (RST_I)
                    CHANNEL_TOGGLE_OUT_O[gi] <= 1'b0;
                else if (CE_I && mode_interval && channel_hit[gi])
                    CHANNEL_TOGGLE_OUT_O[gi] <=
                        ~CHANNEL_TOGGLE_OUT_O[gi];
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Counter, period buffer and enable history
    // ------------------------------------------------------------------
    // Stopping parks the counter at FFFFH ready for the start clear
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state <= itc_pkg::ITC_IDLE;
            enable_q <= 1'b0;
            count <= `ITC_CNT_MAX;
        end
        else if (CE_I)
        begin
            state <= next_state;
            enable_q <= COUNT_ENABLE_I;
            if (next_state != itc_pkg::ITC_RUN)
                count <= `ITC_CNT_MAX;
            else if (start_tick || run_tick)
                count <= next_count;
        end
    end

    // Anytime write: a rewrite reaches the compare at once, even below
    // the running count, which then wraps before matching
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
            period_compare_buffer <= `ITC_CNT_MAX;
        else if (CE_I && (PERIOD_WR_I || enable_rise))
            period_compare_buffer <= PERIOD_COMPARE_I;
    end

    // ------------------------------------------------------------------
    // Registered outputs and decoded pin enables
    // ------------------------------------------------------------------
    // Interrupt outputs register each cycle's hit and hold while CE_I is low; no overflow is ever flagged
    always_ff @(posedge REF_CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            PERIOD_MATCH_IRQ_O <= 1'b0;
            CHANNEL_MATCH_IRQ_O <= '0;
            PERIOD_TOGGLE_OUT_O <= 1'b0;
        end
        else if (CE_I)
        begin
            PERIOD_MATCH_IRQ_O <= period_hit;
            CHANNEL_MATCH_IRQ_O <= channel_hit;
            if (period_toggle)
                PERIOD_TOGGLE_OUT_O <= ~PERIOD_TOGGLE_OUT_O;
        end
        else
        begin
            PERIOD_MATCH_IRQ_O <= PERIOD_MATCH_IRQ_O;
            CHANNEL_MATCH_IRQ_O <= CHANNEL_MATCH_IRQ_O;
        end
    end

    // Readback is a plain tap of the live counter
    assign COUNTER_O = count;
    // Pins are released in event count mode
    assign TOGGLE_OE_O = {(`ITC_NUM_CH + 1){mode_interval}};

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_arm;
        CE_I && enable_rise && mode_ok && state == itc_pkg::ITC_IDLE;
    endsequence

    sequence s_first_count;
        CE_I && start_tick && COUNT_ENABLE_I && mode_ok;
    endsequence

    AST_START_LOADS: assert property (s_arm |=>
        state == itc_pkg::ITC_ARMED && count == `ITC_CNT_MAX
        && period_compare_buffer == $past(PERIOD_COMPARE_I))
        else $error("start did not arm and load the period buffer");

    AST_START_CLEAR: assert property (s_first_count |=>
        count == `ITC_CNT_ZERO && state == itc_pkg::ITC_RUN
        && !PERIOD_MATCH_IRQ_O)
        else $error("first count did not clear FFFFH to zero");

    AST_ZERO_PERIOD: assert property (
        CE_I && run_tick && COUNT_ENABLE_I && mode_ok
        && count == `ITC_CNT_ZERO && period_compare_buffer == `ITC_CNT_ZERO
        && !PERIOD_WR_I |=> count == `ITC_CNT_ZERO && PERIOD_MATCH_IRQ_O)
        else $error("zero period did not hold counter and interrupt");

    AST_PERIOD_CLEAR: assert property (
        CE_I && run_tick && COUNT_ENABLE_I
        && mode_ok && count == period_compare_buffer
        |=> count == `ITC_CNT_ZERO)
        else $error("period match did not clear the counter");

    AST_CH_NO_CLEAR: assert property (
        CE_I && run_tick && COUNT_ENABLE_I
        && mode_ok && count != period_compare_buffer
        |=> count == $past(count) + `ITC_CNT_ONE)
        else $error("counter did not step by one");

    AST_IRQ_VALUE: assert property (PERIOD_MATCH_IRQ_O
        && state == itc_pkg::ITC_RUN
        |-> count == period_compare_buffer || $past(PERIOD_WR_I))
        else $error("period interrupt without counter at compare");

    AST_CH_IRQ: assert property (CE_I && channel_hit[0]
        && COUNT_ENABLE_I && mode_ok
        |=> CHANNEL_MATCH_IRQ_O[0]
        && count == $past(channel_compare_buffers[0]))
        else $error("channel interrupt not tied to its match");

    AST_TOGGLE: assert property (CE_I && mode_interval && period_hit
        |=> PERIOD_TOGGLE_OUT_O != $past(PERIOD_TOGGLE_OUT_O))
        else $error("period output did not toggle on match");

    AST_EVT_NO_OE: assert property (mode_event
        |-> TOGGLE_OE_O == '0)
        else $error("output pin driven in event count mode");

    AST_EVT_HOLD: assert property (CE_I && mode_event
        && state == itc_pkg::ITC_RUN && !ev_edge && COUNT_ENABLE_I
        |=> count == $past(count))
        else $error("event counter moved without an edge");
endmodule

//--- verif/itc_evt_src.sv
// Event source model that drives the timer's event count pin
module itc_evt_src
(
    input wire logic clk_i,
    input wire logic fire_i,
    output logic evt_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------------
    // Pin moves off the clock edge, as a real asynchronous source would
    // One process owns the pin, so it has a single driver
    initial
    begin
        evt_o = 1'b0;
        forever
        begin
            @(posedge clk_i);
            if (fire_i)
            begin
                #1.3 evt_o = 1'b1;
                repeat (10) @(posedge clk_i);
                #1.3 evt_o = 1'b0;
            end
        end
    end
endmodule

//--- verif/interval_and_event_count_timer_bench.sv
// Self-checking bench for the interval and event count timer
`include "itc_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module interval_and_event_count_timer_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------------
    typedef struct {int id; int unit; logic [15:0] cnt; logic lvl; bit lc;}
        itc_note_s;
    logic clk = 0, rst = 1, en = 0, src = 0, tick = 0, pwr = 0, fire = 0;
    logic [2:0] mode = 0;
    logic [1:0] esel = 0;
    logic [15:0] pcmp = 16'hFFFF, cnt_o, ref_c, d0, d;
    logic [47:0] ccmp = '1;
    logic pirq, ptog_o, evt, ptog = 0, prev_e = 0;
    logic [2:0] cirq, ctog_o, ctog = 0, cwr = 0;
    logic [3:0] oe, irq, lvl;
    logic [15:0] chv [3];
    int n_mismatch = 0, num_checks = 0, units = 0, seen = 0;
    bit armed, is_int, use_evt;
    itc_note_s notes[$];
    itc_note_s n;
    always #2 clk = ~clk;
    itc_timer itc_timer_i (.REF_CLK_I(clk), .RST_I(rst), .CE_I(1'b1),
        .COUNT_ENABLE_I(en), .TIMER_MODE_I(mode), .EVENT_SOURCE_SELECT_I(src),
        .EVENT_EDGE_SEL_I(esel), .COUNT_TICK_I(tick), .EVENT_COUNT_I(evt),
        .PERIOD_COMPARE_I(pcmp), .PERIOD_WR_I(pwr), .CHANNEL_COMPARE_I(ccmp),
        .CHANNEL_WR_I(cwr), .COUNTER_O(cnt_o), .PERIOD_MATCH_IRQ_O(pirq),
        .CHANNEL_MATCH_IRQ_O(cirq), .PERIOD_TOGGLE_OUT_O(ptog_o),
        .CHANNEL_TOGGLE_OUT_O(ctog_o), .TOGGLE_OE_O(oe));
    itc_evt_src itc_evt_src_i (.clk_i(clk), .fire_i(fire), .evt_o(evt));
    // ------------------------------------------------------------------
    // Reference model, advanced by one counted unit
    // ------------------------------------------------------------------
    task automatic note(int id, logic l);
        notes.push_back('{id, units, ref_c, l, is_int});
    endtask
    task automatic step();
        units++;
        if (armed)
        begin
            armed = 0;
            ref_c = 16'h0000;
            ptog = ~ptog;
        end
        else
        begin
            ref_c = (ref_c === d0) ? 16'h0000 : ref_c + 16'h0001;
            if (ref_c === d0)
            begin
                ptog ^= is_int;
                note(0, ptog);
            end
            for (int c = 0; c < 3; c++)
                if (ref_c === chv[c])
                begin
                    ctog[c] ^= is_int;
                    note(c + 1, ctog[c]);
                end
        end
    endtask
    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic start(logic [2:0] m, bit s, logic [15:0] p,
        logic [47:0] c);
        en <= 1'b0;
        mode <= m;
        src <= s;
        pcmp <= p;
        ccmp <= c;
        repeat (2) @(posedge clk);
        `CHK(cnt_o, 16'hFFFF)
        en <= 1'b1;
        d0 = p;
        for (int k = 0; k < 3; k++)
            chv[k] = c[16 * k +: 16];
        is_int = (m === `ITC_MODE_INTERVAL);
        armed = is_int;
        ref_c = is_int ? 16'hFFFF : 16'h0000;
        use_evt = s | ~is_int;
        repeat (2) @(posedge clk);
        `CHK(oe, {4{is_int}})
    endtask
    // Negative gap asks for a random spacing between ticks
    task automatic ticks(int cnt, int gap);
        int g;
        for (int k = 0; k < cnt; k++)
        begin
            g = (gap < 0) ? $urandom_range(2) : gap;
            tick <= 1'b1;
            step();
            @(posedge clk);
            if (g > 0)
            begin
                tick <= 1'b0;
                repeat (g) @(posedge clk);
            end
        end
        tick <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulses(int cnt);
        for (int k = 0; k < cnt; k++)
        begin
            fire <= 1'b1;
            @(posedge clk);
            fire <= 1'b0;
            if (esel[0]) step();
            if (esel[1]) step();
            repeat (24) @(posedge clk);
        end
    endtask
    // ------------------------------------------------------------------
    // Monitor: each interrupt takes the oldest note
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        irq = {cirq, pirq};
        lvl = {ctog_o, ptog_o};
        for (int i = 0; i < 4; i++)
            if (!rst && irq[i] !== 1'b0)
            begin
                if (notes.size() == 0)
                    `CHK(irq[i], 1'b0)
                else
                begin
                    n = notes.pop_front();
                    `CHK(i, n.id)
                    `CHK(seen, n.unit)
                    `CHK(cnt_o, n.cnt)
                    if (n.lc) `CHK(lvl[i], n.lvl)
                end
            end
        if (use_evt)
            seen += int'((!prev_e && evt && esel[0]) ||
                (prev_e && !evt && esel[1]));
        else
            seen += int'(tick === 1'b1);
        prev_e = evt;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog sized well past the long wrap scenario
    initial
    begin
        repeat (95000) @(posedge clk);
        n_mismatch++;
        results();
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(24));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        d = 16'h0002 + 16'($urandom_range(3));
        start(`ITC_MODE_INTERVAL, 0, d, {d + 16'h0002, d, 16'h0001});
        ticks(21, -1);
        `CHK(ctog_o, ctog)
        start(`ITC_MODE_INTERVAL, 0, 16'h0000, '1);
        ticks(4, 1);
        start(`ITC_MODE_INTERVAL, 0, 16'h0006, '1);
        ticks(6, 1);
        pcmp <= 16'h0002;
        ccmp <= {32'hFFFFFFFF, 16'h0001};
        pwr <= 1'b1;
        cwr <= 3'h1;
        @(posedge clk);
        pwr <= 1'b0;
        cwr <= 3'h0;
        d0 = 16'h0002;
        chv[0] = 16'h0001;
        @(posedge clk);
        ticks(65536, 0);
        esel <= `ITC_EDGE_RISE;
        start(`ITC_MODE_INTERVAL, 1, 16'h0001, {32'hFFFFFFFF, 16'h0001});
        pulses(6);
        for (int s = 0; s < 4; s++)
        begin
            esel <= 2'(s);
            start(`ITC_MODE_EVENT, 0, 16'h0003, {32'hFFFFFFFF, 16'h0002});
            pulses(7);
        end
        repeat (10) @(posedge clk);
        `CHK(notes.size(), 0)
        results();
    end
endmodule
